/* File: shared/cdi_pkg.sv */
// Constants and types shared by the coil drive and indicator timing core.
// Assumes a single 200 MHz system clock.
package cdi_pkg;
  // ----------------------------------------
  // Clock and rates
  // ----------------------------------------
  localparam longint CDI_CLK_HZ = 200_000_000;
  localparam longint CDI_BRIDGE_HZ = 130_000;
  localparam longint CDI_BRIDGE_FM_HZ = 125_000;
  localparam longint CDI_BUCK_HZ = 520_000;
  localparam longint CDI_BIT_HZ = 2_000;
  localparam longint CDI_FAST_MHZ = 2_500;
  localparam longint CDI_SLOW_MHZ = 625;
  localparam int CDI_BRIDGE_HALF = int'(CDI_CLK_HZ / (2 * CDI_BRIDGE_HZ));
  localparam int CDI_BRIDGE_FM_HALF = int'(CDI_CLK_HZ / (2 * CDI_BRIDGE_FM_HZ));
  localparam int CDI_BUCK_CYC = int'(CDI_CLK_HZ / CDI_BUCK_HZ);
  localparam int CDI_BIT_CYC = int'(CDI_CLK_HZ / CDI_BIT_HZ);
  localparam int CDI_FAST_HALF_CYC = int'((CDI_CLK_HZ * 1000) / (2 * CDI_FAST_MHZ));
  localparam int CDI_SLOW_PER_FAST = int'(CDI_FAST_MHZ / CDI_SLOW_MHZ);
  // ----------------------------------------
  // Widths and packet layout
  // ----------------------------------------
  localparam int CDI_HALF_W = 11;
  localparam int CDI_RAIL_W = 9;
  localparam int CDI_IVL_W = 18;
  localparam logic [CDI_RAIL_W-1:0] CDI_RAIL_INIT = 9'h060;
  localparam logic [CDI_RAIL_W-1:0] CDI_RAIL_MAX = CDI_RAIL_W'(CDI_BUCK_CYC);
  localparam logic [3:0] CDI_PRE_MIN = 4'h4;
  localparam logic [3:0] CDI_BIT_START = 4'h0;
  localparam logic [3:0] CDI_BIT_PAR = 4'h9;
  localparam logic [3:0] CDI_BIT_STOP = 4'hA;
  localparam logic [7:0] CDI_HDR_CTRL_ERR = 8'h03;
  localparam int CDI_LEN_LSB = 5;

  typedef enum logic [1:0] {
    CDI_IND_OFF = 2'b00,
    CDI_IND_ON = 2'b01,
    CDI_IND_SLOW = 2'b10,
    CDI_IND_FAST = 2'b11
  } cdi_ind_t;

  typedef enum logic [0:0] {
    CDI_FR_PRE = 1'b0,
    CDI_FR_DATA = 1'b1
  } cdi_frame_t;
endpackage

/* File: hw/cdi_blink.sv */
// Blink rate divider: slow and fast square waves with equal halves.
// Assumes the core clock; the half period is a parameter so benches can shorten it.
module cdi_blink
  import cdi_pkg::*;
#(
  parameter int FAST_HALF_CYC = CDI_FAST_HALF_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  output logic blink_fast,
  output logic blink_slow,
  output logic slow_tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [1:0] sub;
    logic fast;
    logic slow;
    logic tick;
  } cdi_blink_st_t;

  cdi_blink_st_t st_q, st_d;

  // ----------------------------------------
  // One counter feeds both rates so they never drift apart
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == 32'(FAST_HALF_CYC - 1)) begin
      st_d.cnt = '0;
      st_d.fast = ~st_q.fast;
      st_d.sub = st_q.sub + 2'h1;
      if (st_q.sub == 2'(CDI_SLOW_PER_FAST - 1)) begin
        st_d.slow = ~st_q.slow;
        st_d.tick = 1'b1;
      end
    end else begin
      st_d.cnt = st_q.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign blink_fast = st_q.fast;
  assign blink_slow = st_q.slow;
  assign slow_tick = st_q.tick;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_slow_with_fast: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(blink_slow) |-> $changed(blink_fast))
    else $error("slow blink moved without fast blink");
  a_fast_half_len: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.cnt < 32'(FAST_HALF_CYC))
    else $error("fast blink half period overran");
endmodule

/* File: hw/cdi_core.sv */
// Coil drive and indicator timing core: bridge drive, rail PWM, packet decode, indicators.
// Assumes coil_sense_signal is an already sliced amplitude comparator level and the
// scheme select code is stable while reset is released.
//
// Behaviour
// - Full bridge always switches at exactly fifty percent duty.
// - Bridge frequency is 130 kHz at every power level, and 125 kHz while fm_active is set.
// - Power is set only through the bridge supply rail setpoint.
// - Rail converter control PWM switches at 520 kHz.
// - Packets are preamble, header, message, checksum and are parsed that way.
// - Coil amplitude changes are decoded and adjust the rail setpoint.
// - Messages to the receiver use carrier frequency shifts, not amplitude.
// - Slow blink repeats at 0.625 Hz.
// - Thermal fault kills power at once; fast blink may lag within holdoff.
// - Three indicators driven directly, scheme picked by select input.
module cdi_core
  import cdi_pkg::*;
#(
  parameter int BIT_CYC = CDI_BIT_CYC,
  parameter int FAST_HALF_CYC = CDI_FAST_HALF_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic power_enable,
  input wire logic fm_active,
  input wire logic charge_complete,
  input wire logic coil_sense_signal,
  input wire logic thermistor_fault,
  input wire logic [3:0] indicator_scheme_select,
  output logic bridge_a,
  output logic bridge_b,
  output logic rail_pwm,
  output logic [CDI_RAIL_W-1:0] rail_setpoint,
  output logic packet_ok,
  output logic packet_err,
  output logic indicator_out_first,
  output logic indicator_out_second,
  output logic indicator_out_third
);
  typedef struct packed {
    logic [2:0] sns;
    logic [2:0] flt;
    logic sns_lvl;
    logic flt_lvl;
    logic [3:0] scheme;
    logic scheme_ok;
    logic [CDI_HALF_W-1:0] br_cnt;
    logic br;
    logic [CDI_RAIL_W-1:0] buck_cnt;
    logic pwm;
    logic [CDI_RAIL_W-1:0] rail;
    logic [CDI_IVL_W-1:0] ivl;
    logic half;
    cdi_frame_t fs;
    logic [3:0] ones;
    logic [3:0] bitn;
    logic [7:0] shr;
    logic par;
    logic [3:0] byten;
    logic [7:0] hdr;
    logic [7:0] msg;
    logic [7:0] sum;
    logic ok;
    logic err;
    logic fault_shown;
    logic [2:0] ind;
  } cdi_core_st_t;

  cdi_core_st_t st_q, st_d;
  logic blink_fast, blink_slow, slow_tick;
  logic drive_on;
  cdi_ind_t ind_mode [3];

  cdi_blink #(
    .FAST_HALF_CYC(FAST_HALF_CYC)
  ) u_blink (
    .mclk(mclk),
    .resetn(resetn),
    .blink_fast(blink_fast),
    .blink_slow(blink_slow),
    .slow_tick(slow_tick)
  );

  // Bridge drive is cut the cycle the synchronised fault level is seen; rail PWM drops one cycle later
  assign drive_on = power_enable && !st_q.flt_lvl;

  // ----------------------------------------
  // Indicator scheme map
  // ----------------------------------------
  always_comb begin
    ind_mode[0] = CDI_IND_OFF;
    ind_mode[1] = CDI_IND_OFF;
    ind_mode[2] = CDI_IND_OFF;
    if (st_q.fault_shown) begin
      ind_mode[1] = CDI_IND_FAST;
    end else if (!power_enable) begin
      ind_mode[2] = st_q.scheme[1] ? CDI_IND_ON : CDI_IND_OFF;
    end else if (charge_complete) begin
      ind_mode[0] = CDI_IND_ON;
    end else begin
      ind_mode[0] = st_q.scheme[0] ? CDI_IND_SLOW : CDI_IND_ON;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic edge_seen;
    logic bit_v;
    logic bit_b;
    logic byte_done;
    logic signed [CDI_RAIL_W+1:0] sum_rail;
    edge_seen = 1'b0;
    bit_v = 1'b0;
    bit_b = 1'b0;
    byte_done = 1'b0;
    sum_rail = '0;
    st_d = st_q;
    st_d.ok = 1'b0;
    st_d.err = 1'b0;

    // Three stage synchronisers; a change counts once stages two and three agree
    st_d.sns = {st_q.sns[1:0], coil_sense_signal};
    st_d.flt = {st_q.flt[1:0], thermistor_fault};
    if (st_q.sns[1] == st_q.sns[2]) begin
      edge_seen = st_q.sns[2] != st_q.sns_lvl;
      st_d.sns_lvl = st_q.sns[2];
    end
    if (st_q.flt[1] == st_q.flt[2]) begin
      st_d.flt_lvl = st_q.flt[2];
    end
    if (!st_q.scheme_ok) begin
      st_d.scheme = indicator_scheme_select;
      st_d.scheme_ok = 1'b1;
    end

    // Bridge: both halves equal, only the half length shifts for signalling
    if (!drive_on) begin
      st_d.br_cnt = '0;
      st_d.br = 1'b0;
    end else if (st_q.br_cnt >= CDI_HALF_W'((fm_active ? CDI_BRIDGE_FM_HALF : CDI_BRIDGE_HALF) - 1)) begin
      st_d.br_cnt = '0;
      st_d.br = ~st_q.br;
    end else begin
      st_d.br_cnt = st_q.br_cnt + CDI_HALF_W'(1);
    end

    // Rail converter PWM, duty set by the rail setpoint
    st_d.buck_cnt = (st_q.buck_cnt == CDI_RAIL_W'(CDI_BUCK_CYC - 1)) ? '0
                    : st_q.buck_cnt + CDI_RAIL_W'(1);
    st_d.pwm = drive_on && (st_d.buck_cnt < st_q.rail);

    // Biphase bit recovery from edge spacing
    if (edge_seen) begin
      st_d.ivl = '0;
      if (st_q.ivl < CDI_IVL_W'(BIT_CYC * 3 / 4)) begin
        if (st_q.half) begin
          bit_v = 1'b1;
          bit_b = 1'b1;
          st_d.half = 1'b0;
        end else begin
          st_d.half = 1'b1;
        end
      end else if (st_q.half) begin
        st_d.half = 1'b0;
        st_d.fs = CDI_FR_PRE;
        st_d.ones = '0;
      end else begin
        bit_v = 1'b1;
      end
    end else if (st_q.ivl == CDI_IVL_W'(2 * BIT_CYC)) begin
      // Silence ends any frame in progress
      st_d.fs = CDI_FR_PRE;
      st_d.ones = '0;
      st_d.half = 1'b0;
    end else begin
      st_d.ivl = st_q.ivl + CDI_IVL_W'(1);
    end

    // Packet framing
    if (bit_v) begin
      case (st_q.fs)
        CDI_FR_PRE: begin
          if (bit_b) begin
            st_d.ones = (st_q.ones == 4'hF) ? st_q.ones : st_q.ones + 4'h1;
          end else if (st_q.ones >= CDI_PRE_MIN) begin
            st_d.fs = CDI_FR_DATA;
            st_d.bitn = CDI_BIT_START + 4'h1;
            st_d.byten = '0;
            st_d.par = 1'b0;
          end else begin
            st_d.ones = '0;
          end
        end
        CDI_FR_DATA: begin
          st_d.bitn = st_q.bitn + 4'h1;
          if (st_q.bitn == CDI_BIT_START) begin
            st_d.par = 1'b0;
            if (bit_b) begin
              st_d.fs = CDI_FR_PRE;
              st_d.ones = '0;
            end
          end else if (st_q.bitn < CDI_BIT_PAR) begin
            st_d.shr = {bit_b, st_q.shr[7:1]};
            st_d.par = st_q.par ^ bit_b;
          end else if (st_q.bitn == CDI_BIT_PAR) begin
            st_d.par = st_q.par ^ bit_b;
          end else begin
            st_d.bitn = CDI_BIT_START;
            if (!bit_b || !st_q.par) begin
              st_d.fs = CDI_FR_PRE; // Odd parity and stop bit required
              st_d.ones = '0;
              st_d.err = 1'b1;
            end else begin
              byte_done = 1'b1;
            end
          end
        end
        default: st_d.fs = CDI_FR_PRE;
      endcase
    end

    if (byte_done) begin
      st_d.byten = st_q.byten + 4'h1;
      st_d.sum = st_q.sum ^ st_q.shr;
      if (st_q.byten == '0) begin
        st_d.hdr = st_q.shr;
        st_d.sum = st_q.shr;
      end else if (st_q.byten == 4'h1) begin
        st_d.msg = st_q.shr;
      end
      if (st_q.byten != '0 && st_q.byten == 4'(st_q.hdr[7:CDI_LEN_LSB]) + 4'h2) begin
        st_d.fs = CDI_FR_PRE;
        st_d.ones = '0;
        if (st_q.sum == st_q.shr) begin
          st_d.ok = 1'b1;
        end else begin
          st_d.err = 1'b1;
        end
      end
    end

    // Rail loop: signed request moves the setpoint, clamped to the PWM range
    if (st_q.ok && st_q.hdr == CDI_HDR_CTRL_ERR) begin
      sum_rail = $signed({2'b00, st_q.rail}) + (CDI_RAIL_W+2)'($signed(st_q.msg));
      if (sum_rail < 0) begin
        st_d.rail = '0;
      end else if (sum_rail > $signed({2'b00, CDI_RAIL_MAX})) begin
        st_d.rail = CDI_RAIL_MAX;
      end else begin
        st_d.rail = sum_rail[CDI_RAIL_W-1:0];
      end
    end

    // Fault shown on the next slow tick; lag stays under one slow period
    if (!st_q.flt_lvl) begin
      st_d.fault_shown = 1'b0;
    end else if (slow_tick) begin
      st_d.fault_shown = 1'b1;
    end

    for (int i = 0; i < 3; i++) begin
      case (ind_mode[i])
        CDI_IND_ON: st_d.ind[i] = 1'b1;
        CDI_IND_SLOW: st_d.ind[i] = blink_slow;
        CDI_IND_FAST: st_d.ind[i] = blink_fast;
        default: st_d.ind[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{rail: CDI_RAIL_INIT, fs: CDI_FR_PRE, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bridge_a = drive_on && st_q.br;
  assign bridge_b = drive_on && !st_q.br;
  assign rail_pwm = st_q.pwm;
  assign rail_setpoint = st_q.rail;
  assign packet_ok = st_q.ok;
  assign packet_err = st_q.err;
  assign indicator_out_first = st_q.ind[0];
  assign indicator_out_second = st_q.ind[1];
  assign indicator_out_third = st_q.ind[2];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_bridge_compl: assert property (@(posedge mclk) disable iff (!resetn)
    drive_on |-> bridge_a != bridge_b)
    else $error("bridge legs not complementary");
  a_bridge_half_len: assert property (@(posedge mclk) disable iff (!resetn)
    drive_on && !fm_active && $past(drive_on) && $changed(st_q.br) && !$past(fm_active)
    |-> $past(st_q.br_cnt) == CDI_HALF_W'(CDI_BRIDGE_HALF - 1))
    else $error("bridge half period wrong");
  a_buck_period: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.buck_cnt == CDI_RAIL_W'(CDI_BUCK_CYC - 1) |=> st_q.buck_cnt == '0)
    else $error("rail pwm period wrong");
  a_pwm_duty: assert property (@(posedge mclk) disable iff (!resetn)
    $past(drive_on) && drive_on |-> rail_pwm == (st_q.buck_cnt < $past(st_q.rail)))
    else $error("rail pwm duty not from setpoint");
  a_fault_cuts: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.flt_lvl |-> (!bridge_a && !bridge_b) ##1 !rail_pwm)
    else $error("power still driven during thermal fault");
  a_bad_sum_hold: assert property (@(posedge mclk) disable iff (!resetn)
    packet_err |=> $stable(rail_setpoint))
    else $error("rail moved on a rejected packet");
  a_rail_cause: assert property (@(posedge mclk) disable iff (!resetn)
    $changed(rail_setpoint) |-> $past(packet_ok) && $past(st_q.hdr) == CDI_HDR_CTRL_ERR)
    else $error("rail moved without an accepted request");
  a_fault_blink: assert property (@(posedge mclk) disable iff (!resetn)
    st_q.fault_shown |=> indicator_out_second == $past(blink_fast))
    else $error("fault indicator not fast blinking");
  c_packet_ok: cover property (@(posedge mclk) disable iff (!resetn) packet_ok);
  c_fault_shown: cover property (@(posedge mclk) disable iff (!resetn) $rose(st_q.fault_shown));
  c_fm_bridge: cover property (@(posedge mclk) disable iff (!resetn) fm_active && $changed(bridge_a));
endmodule

/* File: test/cdi_rx_model.sv */
// Receiver model: sends biphase packets by modulating the sensed coil level.
// Assumes send_packet is called just after a rising edge of mclk.
module cdi_rx_model #(
  parameter int BIT_CYC = 40
) (
  input wire logic mclk,
  output logic coil_sense_signal
);
  timeunit 1ns;
  timeprecision 100ps;

  initial coil_sense_signal = 1'b0;

  task automatic half_bit();
    repeat (BIT_CYC / 2) @(posedge mclk);
    #1;
  endtask

  // Load modulation: every bit flips the level, a one flips it again mid-bit
  task automatic send_bit(input logic b);
    coil_sense_signal = ~coil_sense_signal;
    half_bit();
    if (b) coil_sense_signal = ~coil_sense_signal;
    half_bit();
  endtask

  task automatic send_byte(input logic [7:0] d);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(d[i]);
    send_bit(~^d); // Odd parity
    send_bit(1'b1);
  endtask

  // Preamble, header, message, checksum; the trailing silence lets the decoder drop the frame
  task automatic send_packet(input logic [7:0] hdr, input logic [7:0] msg, input logic [7:0] sum);
    repeat (6) send_bit(1'b1);
    send_byte(hdr);
    send_byte(msg);
    send_byte(sum);
    // Closing edge: the decoder only completes a bit at the edge that follows it
    coil_sense_signal = ~coil_sense_signal;
    repeat (3 * BIT_CYC) @(posedge mclk);
    #1;
  endtask
endmodule

/* File: test/tb_cdi_core.sv */
// Self-checking bench for the coil drive and indicator timing core.
// Assumes shortened bit and blink counts; the receiver model drives the coil sense input.
module tb_cdi_core
  import cdi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct {
    logic ok;
    logic [CDI_RAIL_W-1:0] rail;
  } cdi_note_t;

  localparam int BIT_CYC = 40;
  localparam int FAST_HALF = 8;

  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic power_enable = 1'b0;
  logic fm_active = 1'b0;
  logic charge_complete = 1'b0;
  logic thermistor_fault = 1'b0;
  logic [3:0] indicator_scheme_select = 4'h3;
  logic coil_sense_signal;
  logic bridge_a, bridge_b, rail_pwm, packet_ok, packet_err;
  logic indicator_out_first, indicator_out_second, indicator_out_third;
  logic [CDI_RAIL_W-1:0] rail_setpoint;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  int exp_rail = 'h65;
  cdi_note_t notes[$];
  cdi_note_t nt;
  logic [31:0] seed = 32'h106D;
  logic [7:0] msg;

  cdi_core #(.BIT_CYC(BIT_CYC), .FAST_HALF_CYC(FAST_HALF)) cdi_core_inst (
    .mclk(mclk), .resetn(resetn), .power_enable(power_enable), .fm_active(fm_active),
    .charge_complete(charge_complete), .coil_sense_signal(coil_sense_signal),
    .thermistor_fault(thermistor_fault), .indicator_scheme_select(indicator_scheme_select),
    .bridge_a(bridge_a), .bridge_b(bridge_b), .rail_pwm(rail_pwm), .rail_setpoint(rail_setpoint),
    .packet_ok(packet_ok), .packet_err(packet_err), .indicator_out_first(indicator_out_first),
    .indicator_out_second(indicator_out_second), .indicator_out_third(indicator_out_third)
  );

  cdi_rx_model #(.BIT_CYC(BIT_CYC)) cdi_rx_model_inst (
    .mclk(mclk),
    .coil_sense_signal(coil_sense_signal)
  );

  always #2.5 mclk = ~mclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic pick(input int k);
    case (k)
      0: return bridge_a;
      1: return bridge_b;
      2: return rail_pwm;
      3: return indicator_out_first;
      default: return indicator_out_second;
    endcase
  endfunction

  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s: got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_val(input logic [17:0] got, input logic [17:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s: got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  // Inputs and samples sit 1 ns after the edge so no process order matters
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Length of one full high run and the low run after it, in cycles
  task automatic measure(input int k, output int hi, output int lo);
    hi = 0;
    lo = 0;
    while (pick(k) !== 1'b0) cyc(1);
    while (pick(k) !== 1'b1) cyc(1);
    while (pick(k) === 1'b1) begin
      hi++;
      cyc(1);
    end
    while (pick(k) === 1'b0) begin
      lo++;
      cyc(1);
    end
  endtask

  task automatic packet(input logic [7:0] hdr, input logic [7:0] m, input logic [7:0] sum, input logic ok);
    notes.push_back('{ok, CDI_RAIL_W'(exp_rail)});
    cdi_rx_model_inst.send_packet(hdr, m, sum);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      results();
    end
  end

  // Watcher: each result pulse consumes the oldest expectation
  initial forever begin
    cyc(1);
    if (bridge_a === 1'b1 && bridge_b === 1'b1) chk_bit(1'b1, 1'b0, "bridge overlap");
    if (packet_ok === 1'b1 || packet_err === 1'b1) begin
      if (notes.size() == 0) begin
        chk_bit(1'b1, 1'b0, "unexpected packet result");
      end else begin
        nt = notes.pop_front();
        chk_bit(packet_ok, nt.ok, "packet accepted");
        chk_bit(packet_err, ~nt.ok, "packet refused");
        cyc(2);
        chk_val(18'(rail_setpoint), 18'(nt.rail), "rail setpoint");
      end
    end
  end

  initial begin
    int hi;
    int lo;
    cyc(3);
    chk_val(18'(rail_setpoint), 18'h060, "rail reset");
    resetn = 1'b1;
    cyc(5);
    chk_bit(indicator_out_third, 1'b1, "idle indicator");
    power_enable = 1'b1;
    measure(0, hi, lo);
    chk_val(18'(hi), 18'(769), "bridge a high");
    chk_val(18'(lo), 18'(769), "bridge a low");
    measure(1, hi, lo);
    chk_val(18'(hi), 18'(769), "bridge b high");
    fm_active = 1'b1;
    measure(0, hi, lo);
    measure(0, hi, lo);
    chk_val(18'(hi), 18'(800), "fm high");
    chk_val(18'(lo), 18'(800), "fm low");
    fm_active = 1'b0;
    measure(2, hi, lo);
    chk_val(18'(hi), 18'h060, "pwm high");
    chk_val(18'(hi + lo), 18'(384), "pwm period");
    packet(8'h03, 8'h05, 8'h06, 1'b1);
    exp_rail = 'h65;
    packet(8'h03, 8'h05, 8'h07, 1'b0);
    packet(8'h01, 8'h40, 8'h41, 1'b1);
    // Random signed steps stay small so the rail never reaches a clamp
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      msg = {{3{seed[4]}}, seed[4:0]};
      exp_rail += int'($signed(seed[4:0]));
      packet(8'h03, msg, 8'h03 ^ msg, 1'b1);
    end
    for (int t = 0; t < 100 && notes.size() > 0; t++) cyc(1);
    chk_val(18'(notes.size()), 18'(0), "results pending");
    measure(2, hi, lo);
    chk_val(18'(hi), 18'(exp_rail), "pwm follows rail");
    measure(3, hi, lo);
    chk_val(18'(hi), 18'(4 * FAST_HALF), "slow on");
    chk_val(18'(lo), 18'(4 * FAST_HALF), "slow off");
    thermistor_fault = 1'b1;
    cyc(6);
    chk_bit(bridge_a | bridge_b, 1'b0, "fault power cut");
    for (int t = 0; t < 48 && indicator_out_second !== 1'b1; t++) cyc(1);
    chk_bit(indicator_out_second, 1'b1, "fault indication");
    measure(4, hi, lo);
    chk_val(18'(hi), 18'(FAST_HALF), "fast on");
    chk_val(18'(lo), 18'(FAST_HALF), "fast off");
    chk_bit(indicator_out_first, 1'b0, "fault first off");
    thermistor_fault = 1'b0;
    charge_complete = 1'b1;
    cyc(10);
    chk_bit(indicator_out_first, 1'b1, "charged indicator");
    // Second reset with the other scheme code: idle dark, powering lit steady
    power_enable = 1'b0;
    charge_complete = 1'b0;
    indicator_scheme_select = 4'h0;
    resetn = 1'b0;
    cyc(3);
    chk_val(18'(rail_setpoint), 18'h060, "rail reset again");
    resetn = 1'b1;
    cyc(5);
    chk_bit(indicator_out_third, 1'b0, "idle indicator dark");
    power_enable = 1'b1;
    cyc(3);
    chk_bit(indicator_out_first, 1'b1, "steady indicator");
    results();
  end
endmodule
